// File: logic/scnio_core.v
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "scnio_map.vh"

// Overview of operation
// - capture all input terminals into the input image before every scan starts.
// - coil writes go to output image; whole image drives terminals after end.
// - input contacts read the input image, never the terminals directly.
// - output contacts read the output image as last written.
// - input change reaches output terminals one to two scans later.
// - time end-to-end interval and store it as current scan time each end.
// - at each end replace the minimum scan time if the new one is smaller.
// - at each end replace the maximum scan time if the new one is larger.
// - scan time is a millisecond word plus a microsecond word up to 900.
// - measured scan time falls short of the true interval by one clock up to one whole 100 us tick, until the ms word saturates.
// - data words are sixteen bits, top bit gives the sign.
// - signed words span minus 32768 to plus 32767.
// - input refresh keeps running while the program is stopped; output terminals are held off.
// - on stop keep the output image, drive all outputs off, keep other data.
module scnio_core #(
	parameter W = 144,
	parameter AW = 8,
	parameter TICK_CYC = `SCNIO_TICK_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire run_switch,
	input wire [W-1:0] in_terminals,
	output reg [W-1:0] out_terminals,
	output wire scan_start,
	output wire running,
	input wire end_instr,
	input wire coil_we,
	input wire [AW-1:0] coil_addr,
	input wire coil_data,
	input wire contact_from_out,
	input wire [AW-1:0] contact_addr,
	output wire contact_data
);

////////////////////////////////////////////////////////////////////////////////
// scan sequencer states
localparam [3:0] S_INIT = 4'b0001;
localparam [3:0] S_IN = 4'b0010;
localparam [3:0] S_EXEC = 4'b0100;
localparam [3:0] S_OUT = 4'b1000;

reg [3:0] state_q;
reg [3:0] state_d;
reg running_q;
reg running_d;
reg [1:0] ctrl_q;
reg valid_q;
reg [15:0] cur_ms_q;
reg [15:0] cur_us_q;
reg [15:0] min_ms_q;
reg [15:0] min_us_q;
reg [15:0] max_ms_q;
reg [15:0] max_us_q;
reg [15:0] count_q;
reg sel_q;
reg [31:0] rd_d;
reg rd_hit;

wire run_req;
wire in_load;
wire end_ok;
wire coil_ok;
wire meas_valid;
wire [15:0] meas_ms;
wire [15:0] meas_us;
wire [W-1:0] out_image;
wire in_rdata;
wire out_rdata;
wire setup;
wire access;
wire wr_ctrl;
wire clr_req;
wire [31:0] meas_val;
wire [31:0] min_val;
wire [31:0] max_val;

assign run_req = run_switch & ctrl_q[`SCNIO_CTRL_RUN];
assign in_load = (state_q == S_IN);
assign end_ok = (state_q == S_EXEC) && end_instr && run_req;
assign coil_ok = (state_q == S_EXEC) && coil_we && run_req;
assign scan_start = (state_q == S_IN) && running_d;
assign running = running_q;

////////////////////////////////////////////////////////////////////////////////
// scan sequencer
always @* begin
	state_d = state_q;
	running_d = running_q;
	case (state_q)
		S_INIT: begin
			state_d = S_IN;
		end
		S_IN: begin
			// run state is decided at the input capture, then step 0 begins
			running_d = run_req;
			state_d = run_req ? S_EXEC : S_OUT;
		end
		S_EXEC: begin
			if (!run_req) begin
				running_d = 1'b0;
				state_d = S_OUT;
			end else if (end_instr) begin
				state_d = S_OUT;
			end
		end
		S_OUT: begin
			state_d = S_IN;
		end
		default: begin
			state_d = S_INIT;
			running_d = 1'b0;
		end
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_q <= S_INIT;
		running_q <= 1'b0;
	end else begin
		state_q <= state_d;
		running_q <= running_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// input and output images
scnio_image #(
	.W(W),
	.AW(AW)
) u_in_image (
	.pclk(pclk),
	.presetn(presetn),
	.load(in_load),
	.load_data(in_terminals),
	.we(1'b0),
	.waddr({AW{1'b0}}),
	.wdata(1'b0),
	.raddr(contact_addr),
	.rdata_q(in_rdata),
	.image_q()
);

scnio_image #(
	.W(W),
	.AW(AW)
) u_out_image (
	.pclk(pclk),
	.presetn(presetn),
	.load(1'b0),
	.load_data({W{1'b0}}),
	.we(coil_ok),
	.waddr(coil_addr),
	.wdata(coil_data),
	.raddr(contact_addr),
	.rdata_q(out_rdata),
	.image_q(out_image)
);

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sel_q <= 1'b0;
	end else begin
		sel_q <= contact_from_out;
	end
end

// contacts never see the terminals, only the images
assign contact_data = sel_q ? out_rdata : in_rdata;

////////////////////////////////////////////////////////////////////////////////
// output terminals: batch transfer after end, all off while stopped
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		out_terminals <= {W{1'b0}};
	end else if (!run_req || !running_q) begin
		out_terminals <= {W{1'b0}};
	end else if (state_q == S_OUT) begin
		out_terminals <= out_image;
	end
end

////////////////////////////////////////////////////////////////////////////////
// scan time measurement
scnio_scantime #(
	.TICK_CYC(TICK_CYC),
	.DIV_W(16)
) u_scantime (
	.pclk(pclk),
	.presetn(presetn),
	.end_pulse(end_ok),
	.meas_ms_q(meas_ms),
	.meas_us_q(meas_us),
	.meas_valid_q(meas_valid)
);

assign meas_val = {meas_ms, meas_us};
assign min_val = {min_ms_q, min_us_q};
assign max_val = {max_ms_q, max_us_q};
assign clr_req = wr_ctrl && pwdata[`SCNIO_CTRL_CLR];

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cur_ms_q <= `SCNIO_WORD_RST;
		cur_us_q <= `SCNIO_WORD_RST;
		min_ms_q <= `SCNIO_WORD_RST;
		min_us_q <= `SCNIO_WORD_RST;
		max_ms_q <= `SCNIO_WORD_RST;
		max_us_q <= `SCNIO_WORD_RST;
		valid_q <= 1'b0;
		count_q <= `SCNIO_WORD_RST;
	end else if (meas_valid) begin
		// a clear in the same cycle as a new measurement restarts min and max from it
		cur_ms_q <= meas_ms;
		cur_us_q <= meas_us;
		count_q <= count_q + 16'h0001;
		valid_q <= 1'b1;
		if (!valid_q || clr_req || (meas_val < min_val)) begin
			min_ms_q <= meas_ms;
			min_us_q <= meas_us;
		end
		if (!valid_q || clr_req || (meas_val > max_val)) begin
			max_ms_q <= meas_ms;
			max_us_q <= meas_us;
		end
	end else if (clr_req) begin
		valid_q <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave: zero wait states, read data registered in the setup cycle
assign setup = psel && !penable;
assign access = psel && penable;
assign pready = 1'b1;
assign wr_ctrl = access && pwrite && (paddr == `SCNIO_OFS_CTRL);

always @* begin
	rd_d = 32'h00000000;
	rd_hit = 1'b1;
	// 16-bit words in the low half, upper bits read zero
	case (paddr)
		`SCNIO_OFS_CUR_MS: rd_d = {16'h0000, cur_ms_q};
		`SCNIO_OFS_CUR_US: rd_d = {16'h0000, cur_us_q};
		`SCNIO_OFS_MIN_MS: rd_d = {16'h0000, min_ms_q};
		`SCNIO_OFS_MIN_US: rd_d = {16'h0000, min_us_q};
		`SCNIO_OFS_MAX_MS: rd_d = {16'h0000, max_ms_q};
		`SCNIO_OFS_MAX_US: rd_d = {16'h0000, max_us_q};
		`SCNIO_OFS_CTRL: rd_d = {30'h0, ctrl_q[1] & 1'b0, ctrl_q[0]};
		`SCNIO_OFS_STAT: rd_d = {26'h0, valid_q, state_q, running_q};
		`SCNIO_OFS_COUNT: rd_d = {16'h0000, count_q};
		default: rd_hit = 1'b0;
	endcase
end

assign pslverr = access && !rd_hit;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
	end else if (setup && !pwrite) begin
		prdata <= rd_d;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl_q <= `SCNIO_CTRL_RST;
	end else if (wr_ctrl) begin
		ctrl_q <= {1'b0, pwdata[`SCNIO_CTRL_RUN]};
	end
end

endmodule // scnio_core

`default_nettype wire

// File: logic/scnio_map.vh
`ifndef SCNIO_MAP_VH
`define SCNIO_MAP_VH

// register byte offsets
`define SCNIO_OFS_CUR_MS 12'h000
`define SCNIO_OFS_CUR_US 12'h004
`define SCNIO_OFS_MIN_MS 12'h008
`define SCNIO_OFS_MIN_US 12'h00c
`define SCNIO_OFS_MAX_MS 12'h010
`define SCNIO_OFS_MAX_US 12'h014
`define SCNIO_OFS_CTRL 12'h018
`define SCNIO_OFS_STAT 12'h01c
`define SCNIO_OFS_COUNT 12'h020

// control fields
`define SCNIO_CTRL_RUN 0
`define SCNIO_CTRL_CLR 1
`define SCNIO_CTRL_RST 2'h1

// status fields
`define SCNIO_STAT_RUN 0
`define SCNIO_STAT_ST_LO 1
`define SCNIO_STAT_ST_HI 4
`define SCNIO_STAT_VALID 5

// word layout
`define SCNIO_WORD_W 16
`define SCNIO_WORD_RST 16'h0000
`define SCNIO_MS_MAX 16'hffff

// timing
`define SCNIO_CLK_NS 4
`define SCNIO_TICK_NS 100000
`define SCNIO_TICK_CYC (`SCNIO_TICK_NS / `SCNIO_CLK_NS)
`define SCNIO_TICKS_PER_MS 4'h9
`define SCNIO_US_PER_TICK 16'h0064

`endif

// File: logic/scnio_image.v
`timescale 1ns/1ps
`default_nettype none

module scnio_image #(
	parameter W = 144,
	parameter AW = 8
) (
	input wire pclk,
	input wire presetn,
	input wire load,
	input wire [W-1:0] load_data,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire wdata,
	input wire [AW-1:0] raddr,
	output reg rdata_q,
	output wire [W-1:0] image_q
);

reg [W-1:0] bits_q;

assign image_q = bits_q;

////////////////////////////////////////////////////////////////////////////////
// per-bit storage: batch load has priority over a single-bit write
genvar i;
generate
	for (i = 0; i < W; i = i + 1) begin : g_bit
		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				bits_q[i] <= 1'b0;
			end else if (load) begin
				bits_q[i] <= load_data[i];
			end else if (we && (waddr == i)) begin
				bits_q[i] <= wdata;
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// registered single-bit read, out of range reads zero
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rdata_q <= 1'b0;
	end else if (raddr < W) begin
		rdata_q <= bits_q[raddr];
	end else begin
		rdata_q <= 1'b0;
	end
end

endmodule // scnio_image

`default_nettype wire

// File: logic/scnio_scantime.v
`timescale 1ns/1ps
`default_nettype none
`include "scnio_map.vh"

module scnio_scantime #(
	parameter TICK_CYC = `SCNIO_TICK_CYC,
	parameter DIV_W = 16
) (
	input wire pclk,
	input wire presetn,
	input wire end_pulse,
	output reg [15:0] meas_ms_q,
	output reg [15:0] meas_us_q,
	output reg meas_valid_q
);

reg [DIV_W-1:0] div_q;
reg [3:0] sub_q;
reg [15:0] ms_q;
wire tick;

assign tick = (div_q == TICK_CYC - 1);

////////////////////////////////////////////////////////////////////////////////
// 100 us tick divider and tick accumulation, restarted at every end
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		div_q <= {DIV_W{1'b0}};
		sub_q <= 4'h0;
		ms_q <= `SCNIO_WORD_RST;
		meas_ms_q <= `SCNIO_WORD_RST;
		meas_us_q <= `SCNIO_WORD_RST;
		meas_valid_q <= 1'b0;
	end else begin
		meas_valid_q <= end_pulse;
		if (end_pulse) begin
			meas_ms_q <= ms_q;
			meas_us_q <= {12'h000, sub_q} * `SCNIO_US_PER_TICK;
			div_q <= {DIV_W{1'b0}};
			sub_q <= 4'h0;
			ms_q <= `SCNIO_WORD_RST;
		end else if (tick) begin
			div_q <= {DIV_W{1'b0}};
			if (sub_q == `SCNIO_TICKS_PER_MS) begin
				sub_q <= 4'h0;
				if (ms_q != `SCNIO_MS_MAX) begin
					ms_q <= ms_q + 16'h0001;
				end
			end else begin
				sub_q <= sub_q + 4'h1;
			end
		end else begin
			div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end
end

endmodule // scnio_scantime

`default_nettype wire

// File: bench/scnio_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "scnio_map.vh"

module scnio_monitor #(
	parameter W = 144
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic run_switch,
	input wire logic [W-1:0] out_terminals,
	input wire logic scan_start,
	input wire logic running,
	input wire logic end_instr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire rd_acc = psel && penable && !pwrite;
	wire us_reg = paddr == `SCNIO_OFS_CUR_US || paddr == `SCNIO_OFS_MIN_US
		|| paddr == `SCNIO_OFS_MAX_US;
	//////////////////////////////////////////////////////////////////////////
	// accepted end while the run stays on: the next scan starts after one OUT cycle
	sequence s_end;
		end_instr && running && run_switch ##1 run_switch [*2];
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
		else $error("no error on unmapped address");
	a_rescan_end: assert property (s_end |-> scan_start)
		else $error("no input capture after end");
	a_no_scan_stop: assert property (!run_switch && !$past(run_switch) |-> !scan_start)
		else $error("scan started while stopped");
	a_stop_off: assert property (!run_switch [*3] |-> out_terminals == '0)
		else $error("outputs on while stopped");
	a_out_at_end: assert property ($changed(out_terminals) && running && $past(running, 2)
		|-> $past(end_instr, 2)) else $error("outputs moved outside refresh");
	a_us_range: assert property (rd_acc && us_reg |-> prdata % 100 == 0 && prdata <= 900)
		else $error("bad microsecond word");
	a_word_zext: assert property (rd_acc && paddr <= `SCNIO_OFS_MAX_US |-> prdata[31:16] == 0)
		else $error("scan word wider than sixteen bits");
endmodule // scnio_monitor

bind scnio_core scnio_monitor #(.W(W)) i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .run_switch(run_switch), .out_terminals(out_terminals),
	.scan_start(scan_start), .running(running), .end_instr(end_instr));
`default_nettype wire

// File: bench/scnio_prog.sv
`timescale 1ns/1ps
`default_nettype none

// program model: copies one input contact into one output coil, then ends
module scnio_prog (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scan_start,
	input wire logic running,
	input wire logic contact_data,
	input wire logic [9:0] exec_len,
	output logic end_instr,
	output logic coil_we,
	output logic coil_data,
	output logic [7:0] coil_addr,
	output logic [7:0] contact_addr,
	output logic contact_from_out
);
	logic [9:0] cnt_q;
	assign contact_addr = 8'h05;
	assign coil_addr = 8'h1e;
	assign contact_from_out = 1'b0;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 10'h000;
			coil_we <= 1'b0;
			coil_data <= 1'b0;
			end_instr <= 1'b0;
		end else begin
			cnt_q <= scan_start ? 10'h001 : cnt_q + 10'h001;
			coil_we <= running && cnt_q == 10'h003;
			coil_data <= contact_data;
			end_instr <= running && cnt_q == exec_len;
		end
	end
endmodule // scnio_prog
`default_nettype wire

// File: bench/tb_scan_io_refresh_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "scnio_map.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end

module tb_scan_io_refresh_timing;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run_switch = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdata;
	logic pready, pslverr, err, scan_start, running, end_instr, coil_we, coil_data, cfo, cdata;
	logic [7:0] coil_addr, contact_addr;
	logic [143:0] in_t = 0, out_t;
	logic [9:0] exec_len = 10'h190;
	int error_cnt = 0, comparisons = 0, n;
	always #2 pclk = ~pclk;
	scnio_core #(.TICK_CYC(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .run_switch(run_switch), .in_terminals(in_t),
		.out_terminals(out_t), .scan_start(scan_start), .running(running),
		.end_instr(end_instr), .coil_we(coil_we), .coil_addr(coil_addr),
		.coil_data(coil_data), .contact_from_out(cfo), .contact_addr(contact_addr),
		.contact_data(cdata));
	scnio_prog i_prog (.pclk(pclk), .presetn(presetn), .scan_start(scan_start),
		.running(running), .contact_data(cdata), .exec_len(exec_len), .end_instr(end_instr),
		.coil_we(coil_we), .coil_data(coil_data), .coil_addr(coil_addr),
		.contact_addr(contact_addr), .contact_from_out(cfo));
	//////////////////////////////////////////////////////////////////////////
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(0, a, 0);
		`CHK(nm, e, rdata)
	endtask
	task ends(input int k);
		repeat (k) do @(posedge pclk); while (end_instr !== 1'b1);
		repeat (4) @(posedge pclk);
	endtask
	task tally_and_finish;
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////
	task t_regs;
		rd(`SCNIO_OFS_CUR_MS, 0, "cur_ms");
		rd(`SCNIO_OFS_MIN_US, 0, "min_us");
		rd(`SCNIO_OFS_MAX_MS, 0, "max_ms");
		rd(`SCNIO_OFS_CTRL, 1, "ctrl");
		apb(1, `SCNIO_OFS_CUR_MS, 32'h00001234);
		rd(`SCNIO_OFS_CUR_MS, 0, "cur_ms_ro");
		apb(0, 12'h100, 0);
		`CHK("slverr", 1'b1, err)
	endtask
	task t_time;
		ends(1);
		exec_len <= 10'h014;
		ends(3);
		rd(`SCNIO_OFS_MAX_MS, 4, "max_ms");
		rd(`SCNIO_OFS_MIN_MS, 0, "min_ms");
		apb(0, `SCNIO_OFS_MIN_US, 0);
		`CHK("min_us_err", 1'b0, err)
		`CHK("min_us_val", 1'b1, rdata == 200 || rdata == 300)
		exec_len <= 10'h096;
		ends(2);
		rd(`SCNIO_OFS_CUR_MS, 1, "cur_ms");
		apb(0, `SCNIO_OFS_CUR_US, 0);
		`CHK("cur_us_err", 1'b0, err)
		`CHK("cur_us_val", 1'b1, rdata == 500 || rdata == 600)
		rd(`SCNIO_OFS_MAX_MS, 4, "max_hold");
		apb(1, `SCNIO_OFS_CTRL, 32'h00000003);
		ends(2);
		rd(`SCNIO_OFS_MAX_MS, 1, "max_clr");
		rd(`SCNIO_OFS_MIN_MS, 1, "min_clr");
		exec_len <= 10'h014;
		ends(2);
	endtask
	task t_refresh;
		in_t <= 144'h1 << 5;
		n = 0;
		while (out_t[30] !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		`CHK("latency", 1'b1, n > 20 && n <= 50)
		`CHK("out_t", 144'h1 << 30, out_t)
	endtask
	task t_stop;
		run_switch <= 0;
		repeat (30) @(posedge pclk);
		`CHK("out_stop", 144'h0, out_t)
		run_switch <= 1;
		repeat (80) @(posedge pclk);
		`CHK("out_run", 144'h1 << 30, out_t)
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_time;
		t_refresh;
		t_stop;
		tally_and_finish;
	end
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish;
	end
endmodule // tb_scan_io_refresh_timing
`default_nettype wire
